// ==== rtl/hpc_core.sv ====
`include "hpc_params.svh"
`default_nettype none
module hpc_core (
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // channel counts and their strobe, same clock
  input wire hpc_pkg::hpc_chan_s chan,
  input wire logic chan_valid,
  // tuning outputs to the analogue front end
  output hpc_pkg::hpc_tune_s tune1,
  output hpc_pkg::hpc_tune_s tune2,
  // phase constants and compensated ratio to the angle path
  output logic [7:0] sin_phase,
  output logic [7:0] cos_phase,
  output logic [31:0] ratio_out,
  output logic ratio_valid
);
  localparam int W = 32;
  // registers written by software
  logic ctrl_tune_reg; // one cycle auto_tune request
  logic [31:0] tune1_reg; // plate 1 base and target
  logic [31:0] tune2_reg; // plate 2 base and target
  // registers showing block state
  logic [15:0] ref1_reg;
  logic [15:0] ref2_reg;
  logic [15:0] kappa_reg; // 8.8 fixed point
  hpc_pkg::hpc_chan_s raw_reg; // uncompensated counts
  // bus address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic acc_ok;
  assign acc_ok = hsel && hready && htrans[1];

  // address phase capture; zero wait state slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      if (hready) begin
        wr_pend_reg <= acc_ok && hwrite;
        addr_reg <= haddr;
      end
    end
  end

  // always ready, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // software writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_tune_reg <= 1'b0;
      tune1_reg <= `HPC_TUNE1_RST;
      tune2_reg <= `HPC_TUNE2_RST;
      cos_phase <= `HPC_PHASE_RST; // lost on reset
      sin_phase <= `HPC_PHASE_RST;
    end else begin
      ctrl_tune_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (addr_reg)
          `HPC_ADDR_CTRL: ctrl_tune_reg <= hwdata[`HPC_CTRL_TUNE_BIT];
          `HPC_ADDR_TUNE1: tune1_reg <= hwdata;
          `HPC_ADDR_TUNE2: tune2_reg <= hwdata;
          `HPC_ADDR_COSPH: cos_phase <= hwdata[7:0];
          `HPC_ADDR_SINPH: sin_phase <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // read mux, registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (acc_ok && !hwrite) begin
      case (haddr)
        `HPC_ADDR_TUNE1: hrdata <= tune1_reg;
        `HPC_ADDR_TUNE2: hrdata <= tune2_reg;
        `HPC_ADDR_COSPH: hrdata <= {24'h000000, cos_phase};
        `HPC_ADDR_SINPH: hrdata <= {24'h000000, sin_phase};
        `HPC_ADDR_STATUS: hrdata <= {30'h0, tune2.done, tune1.done};
        `HPC_ADDR_REF1: hrdata <= {16'h0000, ref1_reg};
        `HPC_ADDR_REF2: hrdata <= {16'h0000, ref2_reg};
        `HPC_ADDR_KAPPA: hrdata <= {16'h0000, kappa_reg};
        `HPC_ADDR_RATIO: hrdata <= ratio_out;
        // raw counts, no compensation applied
        `HPC_ADDR_RAW12: hrdata <= {raw_reg.plate1_normal_channel,
                                    raw_reg.plate1_inverted_channel};
        `HPC_ADDR_RAW34: hrdata <= {raw_reg.plate2_normal_channel,
                                    raw_reg.plate2_inverted_channel};
        default: hrdata <= '0;
      endcase
    end
  end

  // shared divider, sequenced over the reciprocal, reference and ratio steps
  typedef enum logic [3:0] {
    S_IDLE, S_R1N, S_R1I, S_R2N, S_R2I, S_REF1, S_REF2, S_RAT, S_KAP,
    S_OUT
  } hpc_seq_e;
  hpc_seq_e seq_reg;
  logic dv_start;
  logic [W-1:0] dv_num;
  logic [W-1:0] dv_den;
  logic dv_busy;
  logic dv_done;
  logic [W-1:0] dv_q;
  logic [W-1:0] r1n_reg, r1i_reg, r2n_reg, r2i_reg; // reciprocals
  logic signed [W-1:0] rt_reg, rb_reg; // top, bottom terms
  logic [W-1:0] rat_reg; // raw ratio 8.8
  logic ref_sample; // fresh references pulse

  // absolute value helper
  function automatic logic [W-1:0] absv(input logic signed [W-1:0] v);
    absv = v[W-1] ? W'(-v) : W'(v);
  endfunction

  // divider operands for the current step
  always_comb begin
    dv_num = `HPC_RECIP_NUM;
    dv_den = '0;
    case (seq_reg)
      S_R1N: dv_den = {16'h0000, raw_reg.plate1_normal_channel};
      S_R1I: dv_den = {16'h0000, raw_reg.plate1_inverted_channel};
      S_R2N: dv_den = {16'h0000, raw_reg.plate2_normal_channel};
      S_R2I: dv_den = {16'h0000, raw_reg.plate2_inverted_channel};
      // ref = 1 / (2 * (1/p + 1/p'))
      S_REF1: dv_den = W'((r1n_reg + r1i_reg) << 1);
      S_REF2: dv_den = W'((r2n_reg + r2i_reg) << 1);
      // ratio top over bottom, 8 fraction bits
      S_RAT: begin
        dv_num = W'(absv(rt_reg) << 8);
        dv_den = absv(rb_reg);
      end
      default: ;
    endcase
  end
  assign dv_start = (seq_reg != S_IDLE) && (seq_reg != S_OUT)
                    && (seq_reg != S_KAP) && !dv_busy && !dv_done;

  hpc_recip #(.W(W)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(dv_start),
    .num(dv_num),
    .den(dv_den),
    .busy(dv_busy),
    .done(dv_done),
    .quot(dv_q)
  );

  // arithmetic sequence per channel sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_reg <= S_IDLE;
      raw_reg <= '0;
      r1n_reg <= '0;
      r1i_reg <= '0;
      r2n_reg <= '0;
      r2i_reg <= '0;
      ref1_reg <= '0;
      ref2_reg <= '0;
      rat_reg <= '0;
      ref_sample <= 1'b0;
    end else begin
      ref_sample <= 1'b0;
      case (seq_reg)
        S_IDLE: if (chan_valid) begin
          raw_reg <= chan;
          seq_reg <= S_R1N;
        end
        S_R1N: if (dv_done) begin
          r1n_reg <= dv_q;
          seq_reg <= S_R1I;
        end
        S_R1I: if (dv_done) begin
          r1i_reg <= dv_q;
          seq_reg <= S_R2N;
        end
        S_R2N: if (dv_done) begin
          r2n_reg <= dv_q;
          seq_reg <= S_R2I;
        end
        S_R2I: if (dv_done) begin
          r2i_reg <= dv_q;
          seq_reg <= S_REF1;
        end
        S_REF1: if (dv_done) begin
          ref1_reg <= dv_q[15:0];
          seq_reg <= S_REF2;
        end
        S_REF2: if (dv_done) begin
          ref2_reg <= dv_q[15:0];
          ref_sample <= 1'b1;
          seq_reg <= S_RAT;
        end
        S_RAT: if (dv_done) begin
          rat_reg <= dv_q;
          seq_reg <= S_KAP;
        end
        S_KAP: seq_reg <= S_OUT;
        S_OUT: seq_reg <= S_IDLE;
        default: seq_reg <= S_IDLE;
      endcase
    end
  end

  // top and bottom terms, signed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rt_reg <= '0;
      rb_reg <= '0;
    end else if (seq_reg == S_REF1 && dv_done) begin
      rt_reg <= $signed(r2n_reg) - $signed(r1n_reg);
      rb_reg <= $signed(r2i_reg) - $signed(r1i_reg);
    end
  end

  // rotation tracker: zone by sign of bottom term (half turns)
  hpc_pkg::hpc_zone_e zone_reg;
  hpc_pkg::hpc_zone_e zone_now;
  logic [W-1:0] tmax_reg, bmax_reg; // magnitude maxima this half
  logic [W-1:0] tmin_reg, bmin_reg; // magnitude minima this half
  logic t_ext_reg, b_ext_reg; // extremum seen this half
  logic [W-1:0] kq; // candidate kappa 8.8
  assign zone_now = rb_reg[W-1] ? hpc_pkg::HPC_Z_LOWER
                                : hpc_pkg::HPC_Z_UPPER;
  // combinational kappa, bottom max over top max, 8 fraction bits
  assign kq = (tmax_reg == '0) ? W'(`HPC_KAPPA_ONE)
              : W'(({8'h00, bmax_reg} << 8) / {8'h00, tmax_reg});

  // extrema tracking and kappa update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zone_reg <= hpc_pkg::HPC_Z_UNKNOWN;
      tmax_reg <= '0;
      bmax_reg <= '0;
      tmin_reg <= '1;
      bmin_reg <= '1;
      t_ext_reg <= 1'b0;
      b_ext_reg <= 1'b0;
      kappa_reg <= `HPC_KAPPA_ONE;
    end else if (seq_reg == S_KAP) begin
      if (zone_now != zone_reg) begin
        // crossing 0 or 180: update only if both extrema seen
        if (t_ext_reg && b_ext_reg && zone_reg != hpc_pkg::HPC_Z_UNKNOWN
            && kq != '0) begin
          kappa_reg <= kq[15:0];
        end
        zone_reg <= zone_now;
        tmax_reg <= '0;
        bmax_reg <= '0;
        tmin_reg <= '1;
        bmin_reg <= '1;
        t_ext_reg <= 1'b0;
        b_ext_reg <= 1'b0;
      end else begin
        // an extremum is a peak after which magnitude does not rise
        if (absv(rt_reg) > tmax_reg) tmax_reg <= absv(rt_reg);
        else if (tmax_reg != '0) t_ext_reg <= 1'b1;
        if (absv(rb_reg) > bmax_reg) bmax_reg <= absv(rb_reg);
        else if (bmax_reg != '0) b_ext_reg <= 1'b1;
        if (absv(rt_reg) < tmin_reg) tmin_reg <= absv(rt_reg);
        if (absv(rb_reg) < bmin_reg) bmin_reg <= absv(rb_reg);
      end
    end
  end

  // compensated ratio, angle path only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ratio_out <= '0;
      ratio_valid <= 1'b0;
    end else begin
      ratio_valid <= 1'b0;
      if (seq_reg == S_OUT) begin
        // full width product before the fraction shift
        ratio_out <= W'(({32'h0000_0000, rat_reg} * {48'h0, kappa_reg})
                        >> 8);
        ratio_valid <= 1'b1;
      end
    end
  end

  // phase constants held unchanged, driven straight out

  // auto_tune per plate
  hpc_tuner u_tune1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_tune_reg),
    .sample(ref_sample),
    .ref_val(ref1_reg),
    .base(tune1_reg[`HPC_TUNE_BASE_LSB +: 16]),
    .target(tune1_reg[`HPC_TUNE_TGT_LSB +: 16]),
    .tune(tune1)
  );
  hpc_tuner u_tune2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_tune_reg),
    .sample(ref_sample),
    .ref_val(ref2_reg),
    .base(tune2_reg[`HPC_TUNE_BASE_LSB +: 16]),
    .target(tune2_reg[`HPC_TUNE_TGT_LSB +: 16]),
    .tune(tune2)
  );
endmodule : hpc_core
`default_nettype wire

// ==== rtl/hpc_params.svh ====
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH
// register byte addresses (word aligned)
`define HPC_ADDR_CTRL 8'h00
`define HPC_ADDR_TUNE1 8'h04
`define HPC_ADDR_TUNE2 8'h08
`define HPC_ADDR_COSPH 8'h0C
`define HPC_ADDR_SINPH 8'h10
`define HPC_ADDR_STATUS 8'h14
`define HPC_ADDR_REF1 8'h18
`define HPC_ADDR_REF2 8'h1C
`define HPC_ADDR_KAPPA 8'h20
`define HPC_ADDR_RATIO 8'h24
`define HPC_ADDR_RAW12 8'h28
`define HPC_ADDR_RAW34 8'h2C
// field positions and reset values
`define HPC_CTRL_TUNE_BIT 0
`define HPC_TUNE_BASE_LSB 0
`define HPC_TUNE_TGT_LSB 16
`define HPC_KAPPA_ONE 16'h0100
`define HPC_TUNE1_RST 32'h0200_0064
`define HPC_TUNE2_RST 32'h0200_0064
`define HPC_PHASE_RST 8'h00
`define HPC_RECIP_NUM 32'h0100_0000
`define HPC_FINE_MAX 4'hF
`define HPC_COARSE_MAX 4'hF
`define HPC_COMP_MAX 10'h3FF
`endif

// ==== rtl/hpc_pkg.sv ====
`default_nettype none
package hpc_pkg;
  // four raw channel counts of both plates
  typedef struct packed {
    logic [15:0] plate1_normal_channel;
    logic [15:0] plate1_inverted_channel;
    logic [15:0] plate2_normal_channel;
    logic [15:0] plate2_inverted_channel;
  } hpc_chan_s;
  // per plate tuning result
  typedef struct packed {
    logic [3:0] coarse;
    logic [3:0] fine;
    logic [9:0] comp;
    logic done;
  } hpc_tune_s;
  // auto_tune stages
  typedef enum logic [1:0] {
    HPC_T_IDLE,
    HPC_T_MULT,
    HPC_T_COMP,
    HPC_T_DONE
  } hpc_tune_e;
  // rotation tracker zones
  typedef enum logic [1:0] {
    HPC_Z_UNKNOWN,
    HPC_Z_UPPER,
    HPC_Z_LOWER
  } hpc_zone_e;
endpackage : hpc_pkg
`default_nettype wire

// ==== rtl/hpc_recip.sv ====
`include "hpc_params.svh"
`default_nettype none
// sequential restoring divider, num / den, one result per start
module hpc_recip #(
  parameter int W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quot
);
  logic [W-1:0] rem_reg; // partial remainder
  logic [W-1:0] q_reg; // shifting quotient
  logic [W-1:0] d_reg; // held divisor
  logic [$clog2(W+1)-1:0] cnt_reg; // bits left
  logic [W:0] trial; // remainder shifted with next bit
  assign trial = {rem_reg, q_reg[W-1]};
  // one quotient bit per cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_reg <= '0;
      q_reg <= '0;
      d_reg <= '0;
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      quot <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_reg <= '0;
        q_reg <= num;
        d_reg <= (den == '0) ? {{(W-1){1'b0}}, 1'b1} : den; // avoid /0
        cnt_reg <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, d_reg}) begin
          rem_reg <= W'(trial - {1'b0, d_reg});
          q_reg <= {q_reg[W-2:0], 1'b1};
        end else begin
          rem_reg <= trial[W-1:0];
          q_reg <= {q_reg[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 1'b1;
        if (cnt_reg == 1) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= (trial >= {1'b0, d_reg}) ? {q_reg[W-2:0], 1'b1}
                                           : {q_reg[W-2:0], 1'b0};
        end
      end
    end
  end
endmodule : hpc_recip
`default_nettype wire

// ==== rtl/hpc_tuner.sv ====
`include "hpc_params.svh"
`default_nettype none
// two stage auto_tune for one plate
module hpc_tuner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic sample,
  input wire logic [15:0] ref_val,
  input wire logic [15:0] base,
  input wire logic [15:0] target,
  output hpc_pkg::hpc_tune_s tune
);
  hpc_pkg::hpc_tune_e st_reg; // tuning stage
  // stage machine, one step per fresh reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= hpc_pkg::HPC_T_IDLE;
      tune <= '0;
    end else begin
      case (st_reg)
        hpc_pkg::HPC_T_IDLE: begin
          if (run) begin
            tune <= '0; // compensation forced to zero
            st_reg <= hpc_pkg::HPC_T_MULT;
          end
        end
        hpc_pkg::HPC_T_MULT: begin
          if (sample) begin
            // grow multipliers until ref about base
            if (ref_val < base && tune.coarse != `HPC_COARSE_MAX) begin
              if (tune.fine == `HPC_FINE_MAX) begin
                tune.fine <= '0;
                tune.coarse <= tune.coarse + 1'b1;
              end else begin
                tune.fine <= tune.fine + 1'b1;
              end
            end else begin
              st_reg <= hpc_pkg::HPC_T_COMP;
            end
          end
        end
        hpc_pkg::HPC_T_COMP: begin
          if (sample) begin
            // raise compensation toward target
            if (ref_val < target && tune.comp != `HPC_COMP_MAX) begin
              tune.comp <= tune.comp + 1'b1;
            end else begin
              tune.done <= 1'b1;
              st_reg <= hpc_pkg::HPC_T_DONE;
            end
          end
        end
        hpc_pkg::HPC_T_DONE: begin
          if (run) begin
            tune <= '0; // restart on new request
            st_reg <= hpc_pkg::HPC_T_MULT;
          end
        end
        default: st_reg <= hpc_pkg::HPC_T_IDLE;
      endcase
    end
  end
endmodule : hpc_tuner
`default_nettype wire

// ==== testbench/hpc_core_asserts.sv ====
`include "hpc_params.svh"
`default_nettype none
// watches bus answers, phase registers, tuning and ratio pulses
module hpc_core_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire hpc_pkg::hpc_tune_s tune1,
  input wire hpc_pkg::hpc_tune_s tune2,
  input wire logic [7:0] sin_phase,
  input wire logic [7:0] cos_phase,
  input wire logic [31:0] ratio_out,
  input wire logic ratio_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // address phase of a write taken by the slave
  logic wr_take;
  logic wr_cos;
  logic wr_sin;
  assign wr_take = hsel & hready & htrans[1] & hwrite;
  assign wr_cos = wr_take & (haddr == `HPC_ADDR_COSPH);
  assign wr_sin = wr_take & (haddr == `HPC_ADDR_SINPH);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_cos_write: assert property (
    wr_cos |=> ##1 (cos_phase == $past(hwdata[7:0])))
    else $error("cosine constant not stored");
  a_sin_write: assert property (
    wr_sin |=> ##1 (sin_phase == $past(hwdata[7:0])))
    else $error("sine constant not stored");
  a_phase_held: assert property (
    ($changed(cos_phase) || $changed(sin_phase))
    |-> ($past(wr_cos, 2) || $past(wr_sin, 2)))
    else $error("phase constant moved without a write");
  a_reset_phase: assert property (
    !$past(hresetn) |-> (cos_phase == 8'h00) && (sin_phase == 8'h00))
    else $error("phase constants survived reset");
  a_mult_stage: assert property (
    ($changed({tune1.coarse, tune1.fine}) |-> (tune1.comp == 10'h000))
    and ($changed({tune2.coarse, tune2.fine}) |-> (tune2.comp == 10'h000)))
    else $error("multipliers moved with compensation set");
  a_done_hold: assert property (
    (tune2.done && $past(tune2.done))
    |-> $stable(tune2.comp) && $stable(tune2.fine))
    else $error("tuning moved after done");
  a_ratio_pulse: assert property (ratio_valid |=> !ratio_valid)
    else $error("ratio strobe longer than one cycle");
  a_ratio_stands: assert property (
    ratio_valid |=> $stable(ratio_out) [*8])
    else $error("ratio output did not stand");
  // main scenarios seen
  c_ratio: cover property (ratio_valid);
  c_cos: cover property (wr_cos);
  c_done: cover property ($rose(tune2.done));
endmodule // hpc_core_asserts
bind hpc_core hpc_core_asserts chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .tune1(tune1), .tune2(tune2), .sin_phase(sin_phase),
  .cos_phase(cos_phase), .ratio_out(ratio_out),
  .ratio_valid(ratio_valid));
`default_nettype wire

// ==== testbench/hpc_host.sv ====
`include "hpc_params.svh"
`default_nettype none
// host controller model, single word ahb-lite transfers
module hpc_host (
  input wire logic hclk,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // one transfer: address phase held until ready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // setup after every reset: tuning first, then phase constants
  task automatic setup(input logic [7:0] cs, input logic [7:0] sn);
    wr(`HPC_ADDR_TUNE1, {16'h01F4, 16'h0064});
    wr(`HPC_ADDR_TUNE2, {16'h01F4, 16'h0096});
    wr(`HPC_ADDR_COSPH, {24'h0, cs});
    wr(`HPC_ADDR_SINPH, {24'h0, sn});
  endtask
endmodule // hpc_host
`default_nettype wire

// ==== testbench/hall_phase_compensation_tb.sv ====
`include "hpc_params.svh"
`default_nettype none
// bench: register traffic through the host model, counts fed directly
module hall_phase_compensation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  hpc_pkg::hpc_chan_s chan;
  logic chan_valid;
  hpc_pkg::hpc_tune_s tune1;
  hpc_pkg::hpc_tune_s tune2;
  logic [7:0] sin_phase;
  logic [7:0] cos_phase;
  logic [31:0] ratio_out;
  logic ratio_valid;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  hpc_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan(chan),
    .chan_valid(chan_valid), .tune1(tune1), .tune2(tune2),
    .sin_phase(sin_phase), .cos_phase(cos_phase),
    .ratio_out(ratio_out), .ratio_valid(ratio_valid));
  hpc_host host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hready(hreadyout));
  // 4 ns clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register read compare under a mask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] m);
    logic [31:0] q;
    host_u.rd(a, q);
    chk(q & m, exp);
  endtask
  // expected plate reference: one over twice the reciprocal sum
  function automatic logic [31:0] ref_of(input int a, input int b);
    return 32'(a * b / (2 * (a + b)));
  endfunction
  // one sample, optionally a second strobe while busy, wait for result
  task automatic feed(input logic [15:0] a, input logic [15:0] b,
    input logic [15:0] c, input logic [15:0] d, input bit junk);
    repeat (2) @(posedge hclk);
    chan <= {a, b, c, d};
    chan_valid <= 1'b1;
    @(posedge hclk);
    chan_valid <= 1'b0;
    if (junk) begin
      repeat (5) @(posedge hclk);
      chan <= {16'h0032, 16'h005A, 16'h0046, 16'h001E};
      chan_valid <= 1'b1;
      @(posedge hclk);
      chan_valid <= 1'b0;
    end
    do @(posedge hclk); while (ratio_valid !== 1'b1);
  endtask
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  initial begin
    hresetn = 1'b0;
    chan = '0;
    chan_valid = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // values after reset
    chk_rd(`HPC_ADDR_KAPPA, 32'h0000_0100, ALL);
    chk_rd(`HPC_ADDR_TUNE1, `HPC_TUNE1_RST, ALL);
    chk_rd(`HPC_ADDR_COSPH, 32'h0, ALL);
    chk_rd(8'h3C, 32'h0, ALL);
    host_u.setup(8'h83, 8'hDA);
    host_u.wr(8'h3C, ALL);
    chk_rd(8'h3C, 32'h0, ALL);
    chk_rd(`HPC_ADDR_COSPH, 32'h83, ALL);
    chk_rd(`HPC_ADDR_SINPH, 32'hDA, ALL);
    chk({24'h0, cos_phase}, 32'h83);
    chk({24'h0, sin_phase}, 32'hDA);
    // equal top and bottom terms give a ratio of one
    feed(16'h0190, 16'h0190, 16'h00C8, 16'h00C8, 1'b0);
    chk_rd(`HPC_ADDR_REF1, ref_of(400, 400), 32'hFFFF);
    chk_rd(`HPC_ADDR_REF2, ref_of(200, 200), 32'hFFFF);
    chk(ratio_out, 32'h0000_0100);
    chk_rd(`HPC_ADDR_RAW12, {16'd400, 16'd400}, ALL);
    // top term three times bottom, stray strobe while busy
    feed(16'h0190, 16'h0190, 16'h0064, 16'h00C8, 1'b1);
    chk(ratio_out, 32'h0000_0300);
    chk_rd(`HPC_ADDR_KAPPA, 32'h0000_0100, ALL);
    // tuning: plate1 stays below target, plate2 meets it at once
    host_u.wr(`HPC_ADDR_CTRL, 32'h1);
    repeat (6) feed(16'h0258, 16'h0258, 16'h0960, 16'h0960, 1'b0);
    chk({31'h0, tune2.done}, 32'h1);
    chk({22'h0, tune2.comp}, 32'h0);
    chk({31'h0, tune1.done}, 32'h0);
    chk({31'h0, tune1.comp != 10'h000}, 32'h1);
    chk_rd(`HPC_ADDR_STATUS, 32'h2, 32'h3);
    // larger bottom swing in this lower half, then cross to the upper half
    feed(16'h0258, 16'h012C, 16'h0960, 16'h0960, 1'b0);
    feed(16'h0190, 16'h0190, 16'h00C8, 16'h00C8, 1'b0);
    // kappa = 48934 * 256 / 20972 from the 2^24 reciprocals
    chk_rd(`HPC_ADDR_KAPPA, 32'h0000_0255, ALL);
    chk(ratio_out, 32'h0000_0255);
    // plate2 again with a base above its reference: multipliers grow
    host_u.wr(`HPC_ADDR_TUNE2, {16'h01F4, 16'h03E8});
    host_u.wr(`HPC_ADDR_CTRL, 32'h0000_0001);
    repeat (2) feed(16'h0258, 16'h0258, 16'h0960, 16'h0960, 1'b0);
    chk({28'h0, tune2.fine}, 32'h2);
    chk({22'h0, tune2.comp}, 32'h0);
    chk({31'h0, tune2.done}, 32'h0);
    // second reset drops the constants until rewritten
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(`HPC_ADDR_SINPH, 32'h0, ALL);
    host_u.setup(8'h83, 8'hDA);
    chk({24'h0, cos_phase}, 32'h83);
    finish_test();
  end
endmodule // hall_phase_compensation_tb
`default_nettype wire
